/* core/dtc_timer_pair.v */
// Two timer/counter units with their control, mode and count registers.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
`include "dtc_defines.vh"
module dtc_timer_pair (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  input wire gate_pin_a_i,
  input wire gate_pin_b_i,
  input wire count_input_pin_a_i,
  input wire count_input_pin_b_i,
  input wire isr_ack_a_i,
  input wire isr_ack_b_i,
  output wire overflow_flag_a_o,
  output wire overflow_flag_b_o
);

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  // Count bytes are live registers; a 16-bit value is read as two bytes and can tear
  // while the unit runs, so software should stop the unit or read the high byte twice.
  reg [7:0] ctrl_r;
  reg [7:0] mode_r;
  reg [7:0] count_low_byte_a_r;
  reg [7:0] count_high_byte_a_r;
  reg [7:0] count_low_byte_b_r;
  reg [7:0] count_high_byte_b_r;
  reg tick_cnt_r;
  reg pin_a_d_r;
  reg pin_b_d_r;

  // Field views of the control and mode registers.
  wire run_control_a = ctrl_r[`DTC_CTRL_RUN_A];
  wire run_control_b = ctrl_r[`DTC_CTRL_RUN_B];
  wire pin_gating_a = mode_r[`DTC_MODE_GATE_A];
  wire pin_gating_b = mode_r[`DTC_MODE_GATE_B];
  wire count_source_select_a = mode_r[`DTC_MODE_SRC_A];
  wire count_source_select_b = mode_r[`DTC_MODE_SRC_B];
  wire [1:0] mode_field_a = mode_r[`DTC_MODE_FLD_A_HI:`DTC_MODE_FLD_A_LO];
  wire [1:0] mode_field_b = mode_r[`DTC_MODE_FLD_B_HI:`DTC_MODE_FLD_B_LO];
  wire split_mode = (mode_field_a == `DTC_MODE_SPLIT);
  // Control bits 3..0 belong to the external interrupt logic; here they are plain storage
  // that software can write and read back, with no behaviour behind them.

  // ****************************************************************
  // Time base and pin edge detection
  // ****************************************************************
  // The 2-cycle time base is a shared enable pulse, so both units step in the same cycle.
  // The divider runs free from reset and is never restarted by the run bit, so the first
  // step after starting a unit comes one or two cycles later.
  // A free-running divider keeps both units on one phase, which was worth more here
  // than an exact first step.
  wire tick = (tick_cnt_r == `DTC_TICK_CNT_MAX);

  // Pins are taken as synchronous; a falling edge is a high sample followed by a low one.
  // A pulse narrower than the tick can still be seen here, but only wider ones are promised.
  // The delayed samples reset low, so a pin that idles high gives no false edge after reset.
  wire fall_a = pin_a_d_r & ~count_input_pin_a_i;
  wire fall_b = pin_b_d_r & ~count_input_pin_b_i;

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_cnt_r <= 1'b0;
      pin_a_d_r <= 1'b0;
      pin_b_d_r <= 1'b0;
    end else begin
      tick_cnt_r <= ~tick_cnt_r;
      pin_a_d_r <= count_input_pin_a_i;
      pin_b_d_r <= count_input_pin_b_i;
    end
  end

  // ****************************************************************
  // Count enables
  // ****************************************************************
  // Gating needs both the run bit and a high gate pin; otherwise the run bit alone decides.
  wire en_a = run_control_a & (~pin_gating_a | gate_pin_a_i);
  wire en_b = run_control_b & (~pin_gating_b | gate_pin_b_i);
  wire step_a = en_a & (count_source_select_a ? fall_a : tick);
  wire step_b = en_b & (count_source_select_b ? fall_b : tick);
  // The split high byte is a pure timer run by unit B's run bit.
  // It ignores gating and the pin on purpose: in split mode unit B's own pins keep
  // steering unit B's counter, which still runs but no longer owns the flag.
  wire step_split_hi = run_control_b & tick;

  // ****************************************************************
  // Counting arithmetic, one combinational view per unit
  // ****************************************************************
  reg [7:0] low_a_nxt;
  reg [7:0] high_a_nxt;
  reg [7:0] low_b_nxt;
  reg [7:0] high_b_nxt;
  reg ovf_a;
  reg ovf_b_own;
  reg ovf_split_hi;

  // Unit A: all four modes.
  // Each branch only looks at the step of its own byte, so a stopped unit costs nothing
  // here and the case stays a pure function of the current registers.
  always @* begin
    low_a_nxt = count_low_byte_a_r;
    high_a_nxt = count_high_byte_a_r;
    ovf_a = 1'b0;
    ovf_split_hi = 1'b0;
    case (mode_field_a)
      // Mode 00: the low five bits prescale, the upper three low bits are kept as they are.
      `DTC_MODE_PRESCALE: begin
        if (step_a) begin
          if (count_low_byte_a_r[4:0] == `DTC_PRESCALE_MAX) begin
            low_a_nxt = {count_low_byte_a_r[7:5], 5'h00};
            high_a_nxt = count_high_byte_a_r + `DTC_ONE;
            ovf_a = (count_high_byte_a_r == `DTC_BYTE_MAX);
          end else begin
            low_a_nxt = count_low_byte_a_r + `DTC_ONE;
          end
        end
      end
      // Mode 01: one 16-bit count, the high byte steps on the low byte's carry.
      `DTC_MODE_WIDE: begin
        if (step_a) begin
          low_a_nxt = count_low_byte_a_r + `DTC_ONE;
          if (count_low_byte_a_r == `DTC_BYTE_MAX) begin
            high_a_nxt = count_high_byte_a_r + `DTC_ONE;
            ovf_a = (count_high_byte_a_r == `DTC_BYTE_MAX);
          end
        end
      end
      // Mode 10: the high byte is only the reload value and never counts here.
      `DTC_MODE_RELOAD: begin
        if (step_a) begin
          if (count_low_byte_a_r == `DTC_BYTE_MAX) begin
            low_a_nxt = count_high_byte_a_r;
            ovf_a = 1'b1;
          end else begin
            low_a_nxt = count_low_byte_a_r + `DTC_ONE;
          end
        end
      end
      // Mode 11: two 8-bit timers share unit A's bytes; the high one is run by unit B.
      // The two halves step independently, so both flags may rise in the same cycle.
      `DTC_MODE_SPLIT: begin
        if (step_a) begin
          low_a_nxt = count_low_byte_a_r + `DTC_ONE;
          ovf_a = (count_low_byte_a_r == `DTC_BYTE_MAX);
        end
        if (step_split_hi) begin
          high_a_nxt = count_high_byte_a_r + `DTC_ONE;
          ovf_split_hi = (count_high_byte_a_r == `DTC_BYTE_MAX);
        end
      end
      default: begin
        low_a_nxt = count_low_byte_a_r;
      end
    endcase
  end

  // Unit B: mode 11 stops it; it keeps running beside a split unit A but loses its flag.
  // It has no split branch of its own; its high byte never counts on its own tick.
  always @* begin
    low_b_nxt = count_low_byte_b_r;
    high_b_nxt = count_high_byte_b_r;
    ovf_b_own = 1'b0;
    case (mode_field_b)
      // Mode 00: same prescaler as unit A.
      `DTC_MODE_PRESCALE: begin
        if (step_b) begin
          if (count_low_byte_b_r[4:0] == `DTC_PRESCALE_MAX) begin
            low_b_nxt = {count_low_byte_b_r[7:5], 5'h00};
            high_b_nxt = count_high_byte_b_r + `DTC_ONE;
            ovf_b_own = (count_high_byte_b_r == `DTC_BYTE_MAX);
          end else begin
            low_b_nxt = count_low_byte_b_r + `DTC_ONE;
          end
        end
      end
      // Mode 01: one 16-bit count.
      `DTC_MODE_WIDE: begin
        if (step_b) begin
          low_b_nxt = count_low_byte_b_r + `DTC_ONE;
          if (count_low_byte_b_r == `DTC_BYTE_MAX) begin
            high_b_nxt = count_high_byte_b_r + `DTC_ONE;
            ovf_b_own = (count_high_byte_b_r == `DTC_BYTE_MAX);
          end
        end
      end
      // Mode 10: low byte counts and reloads from the high byte.
      `DTC_MODE_RELOAD: begin
        if (step_b) begin
          if (count_low_byte_b_r == `DTC_BYTE_MAX) begin
            low_b_nxt = count_high_byte_b_r;
            ovf_b_own = 1'b1;
          end else begin
            low_b_nxt = count_low_byte_b_r + `DTC_ONE;
          end
        end
      end
      // Mode 11 stops unit B: both bytes hold and it raises no overflow of its own.
      default: begin
        low_b_nxt = count_low_byte_b_r;
      end
    endcase
  end

  // In split mode unit B's flag belongs to unit A's high byte.
  // Unit B's own overflow is dropped then, since the flag has only one owner at a time.
  wire ovf_b = split_mode ? ovf_split_hi : ovf_b_own;

  // ****************************************************************
  // Register writes and hardware updates
  // ****************************************************************
  // A software write to a count byte wins over counting in that cycle, since software
  // intent is explicit; hardware flag setting wins over both software and ISR clears.
  // Writing a flag bit to one from software sets it, as on any plain register bit.
  wire wr_ctrl = reg_wr_i & (reg_addr_i == `DTC_ADDR_CTRL);
  reg [7:0] ctrl_nxt;

  // The order of the statements below is the priority: software write first, then the
  // service entry clears, and last the hardware sets, so an overflow that lands in the
  // same cycle as a clear is never lost.
  always @* begin
    ctrl_nxt = wr_ctrl ? reg_wdata_i : ctrl_r;
    if (isr_ack_a_i) begin
      ctrl_nxt[`DTC_CTRL_OVF_A] = 1'b0;
    end
    if (isr_ack_b_i) begin
      ctrl_nxt[`DTC_CTRL_OVF_B] = 1'b0;
    end
    if (ovf_a) begin
      ctrl_nxt[`DTC_CTRL_OVF_A] = 1'b1;
    end
    if (ovf_b) begin
      ctrl_nxt[`DTC_CTRL_OVF_B] = 1'b1;
    end
  end

  // ****************************************************************
  // Write decode
  // ****************************************************************
  // One decode per register keeps each update process small and easy to check.
  wire wr_mode = reg_wr_i & (reg_addr_i == `DTC_ADDR_MODE);
  wire wr_low_a = reg_wr_i & (reg_addr_i == `DTC_ADDR_LOW_A);
  wire wr_high_a = reg_wr_i & (reg_addr_i == `DTC_ADDR_HIGH_A);
  wire wr_low_b = reg_wr_i & (reg_addr_i == `DTC_ADDR_LOW_B);
  wire wr_high_b = reg_wr_i & (reg_addr_i == `DTC_ADDR_HIGH_B);

  // Control and mode registers; the flags reach the outputs straight from here.
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_r <= `DTC_RESET_BYTE;
      mode_r <= `DTC_RESET_BYTE;
    end else begin
      ctrl_r <= ctrl_nxt;
      if (wr_mode) begin
        // A mode change acts on the next step; a half-done prescale count is kept.
        mode_r <= reg_wdata_i;
      end
    end
  end

  // Unit A count bytes. A write wins over a step in the same cycle, so that step is lost.
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_low_byte_a_r <= `DTC_RESET_BYTE;
      count_high_byte_a_r <= `DTC_RESET_BYTE;
    end else begin
      if (wr_low_a) begin
        count_low_byte_a_r <= reg_wdata_i;
      end else begin
        count_low_byte_a_r <= low_a_nxt;
      end
      if (wr_high_a) begin
        count_high_byte_a_r <= reg_wdata_i;
      end else begin
        count_high_byte_a_r <= high_a_nxt;
      end
    end
  end

  // Unit B count bytes, built the same way as unit A.
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_low_byte_b_r <= `DTC_RESET_BYTE;
      count_high_byte_b_r <= `DTC_RESET_BYTE;
    end else begin
      if (wr_low_b) begin
        count_low_byte_b_r <= reg_wdata_i;
      end else begin
        count_low_byte_b_r <= low_b_nxt;
      end
      if (wr_high_b) begin
        count_high_byte_b_r <= reg_wdata_i;
      end else begin
        count_high_byte_b_r <= high_b_nxt;
      end
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  // Read data appear one cycle after the strobe and only then; otherwise zero.
  // Returning zero between reads keeps the shared read bus quiet, and unmapped places
  // read as zero so that software can probe the map without side effects.
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= `DTC_RESET_BYTE;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `DTC_ADDR_CTRL: reg_rdata_o <= ctrl_r;
        `DTC_ADDR_MODE: reg_rdata_o <= mode_r;
        `DTC_ADDR_LOW_A: reg_rdata_o <= count_low_byte_a_r;
        `DTC_ADDR_HIGH_A: reg_rdata_o <= count_high_byte_a_r;
        `DTC_ADDR_LOW_B: reg_rdata_o <= count_low_byte_b_r;
        `DTC_ADDR_HIGH_B: reg_rdata_o <= count_high_byte_b_r;
        default: reg_rdata_o <= `DTC_RESET_BYTE;
      endcase
    end else begin
      reg_rdata_o <= `DTC_RESET_BYTE;
    end
  end

  // ****************************************************************
  // Flag outputs
  // ****************************************************************
  // The flags leave straight from the control register, so what software reads and
  // what the interrupt logic sees can never differ.
  assign overflow_flag_a_o = ctrl_r[`DTC_CTRL_OVF_A];
  assign overflow_flag_b_o = ctrl_r[`DTC_CTRL_OVF_B];

endmodule // dtc_timer_pair

/* inc/dtc_defines.vh */
// Register offsets, field positions and timing constants of the dual timer/counter.
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH
// ****************************************************************
// Register map
// ****************************************************************
`define DTC_ADDR_CTRL 8'h88
`define DTC_ADDR_MODE 8'h89
`define DTC_ADDR_LOW_A 8'h8a
`define DTC_ADDR_LOW_B 8'h8b
`define DTC_ADDR_HIGH_A 8'h8c
`define DTC_ADDR_HIGH_B 8'h8d
`define DTC_RESET_BYTE 8'h00
// ****************************************************************
// Control register bits
// ****************************************************************
`define DTC_CTRL_OVF_B 7
`define DTC_CTRL_RUN_B 6
`define DTC_CTRL_OVF_A 5
`define DTC_CTRL_RUN_A 4
`define DTC_CTRL_EXT_FLAG_B 3
`define DTC_CTRL_EXT_TYPE_B 2
`define DTC_CTRL_EXT_FLAG_A 1
`define DTC_CTRL_EXT_TYPE_A 0
// ****************************************************************
// Mode register fields
// ****************************************************************
`define DTC_MODE_GATE_B 7
`define DTC_MODE_SRC_B 6
`define DTC_MODE_FLD_B_HI 5
`define DTC_MODE_FLD_B_LO 4
`define DTC_MODE_GATE_A 3
`define DTC_MODE_SRC_A 2
`define DTC_MODE_FLD_A_HI 1
`define DTC_MODE_FLD_A_LO 0
`define DTC_MODE_PRESCALE 2'b00
`define DTC_MODE_WIDE 2'b01
`define DTC_MODE_RELOAD 2'b10
`define DTC_MODE_SPLIT 2'b11
// ****************************************************************
// Counting widths and timing
// ****************************************************************
`define DTC_PRESCALE_MAX 8'h1f
`define DTC_BYTE_MAX 8'hff
`define DTC_ONE 8'h01
`define DTC_TICK_CYCLES 2
`define DTC_TICK_CNT_MAX 1'b1
`endif

/* verification/dtc_asserts.sv */
// Port-level concurrent checks for the dual timer/counter.
`timescale 1ns/1ns
module dtc_asserts (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire isr_ack_a_i,
  input wire isr_ack_b_i,
  input wire overflow_flag_a_o,
  input wire overflow_flag_b_o
);
  // ****************************************************************
  // Shadow registers and properties
  // ****************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  reg [7:0] ctrl_r;
  reg [7:0] mode_r;
  wire ctrl_wr = reg_wr_i && (reg_addr_i == 8'h88);
  // Run and mode bits only change by software, so a bus shadow is exact.
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_r <= 8'h00;
      mode_r <= 8'h00;
    end else begin
      if (ctrl_wr) ctrl_r <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == 8'h89) mode_r <= reg_wdata_i;
    end
  end
  a_rdata_idle_zero: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  a_mode_read_back: assert property (reg_wr_i && reg_addr_i == 8'h89 ##2
    reg_rd_i && reg_addr_i == 8'h89 |=> reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("mode register read back differs");
  a_flag_a_hold: assert property (overflow_flag_a_o && !isr_ack_a_i && !ctrl_wr
    |=> overflow_flag_a_o) else $error("flag a dropped without cause");
  a_flag_b_hold: assert property (overflow_flag_b_o && !isr_ack_b_i && !ctrl_wr
    |=> overflow_flag_b_o) else $error("flag b dropped without cause");
  a_ack_a_clear: assert property (isr_ack_a_i && !ctrl_wr |=> !overflow_flag_a_o)
    else $error("flag a not cleared by service entry");
  a_ack_b_clear: assert property (isr_ack_b_i && !ctrl_wr |=> !overflow_flag_b_o)
    else $error("flag b not cleared by service entry");
  a_run_a_needed: assert property ($rose(overflow_flag_a_o) && !$past(ctrl_wr)
    |-> $past(ctrl_r[4])) else $error("flag a set while unit a stopped");
  a_run_b_needed: assert property ($rose(overflow_flag_b_o) && !$past(ctrl_wr)
    |-> $past(ctrl_r[6])) else $error("flag b set while run b off");
  a_stop_b_quiet: assert property (mode_r[5:4] == 2'b11 && mode_r[1:0] != 2'b11
    && !ctrl_wr |=> !$rose(overflow_flag_b_o)) else $error("stopped unit b flagged");
  // The main scenarios should each be reached.
  cover property ($rose(overflow_flag_a_o));
  cover property ($rose(overflow_flag_b_o));
  cover property (isr_ack_b_i && overflow_flag_b_o);
endmodule // dtc_asserts
bind dtc_timer_pair dtc_asserts u_chk (.clk_sys_i, .rst_b_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o, .isr_ack_a_i, .isr_ack_b_i, .overflow_flag_a_o,
  .overflow_flag_b_o);

/* verification/dtc_pin_model.sv */
// Behavioural source for the external count pins of both units.
`timescale 1ns/1ns
module dtc_pin_model (
  input wire clk_sys_i,
  input wire pulse_a_i,
  input wire pulse_b_i,
  output reg count_input_pin_a_o,
  output reg count_input_pin_b_o
);
  // ****************************************************************
  // Pulse shaping
  // ****************************************************************
  reg [2:0] low_a_r = 3'h0;
  reg [2:0] low_b_r = 3'h0;
  initial count_input_pin_a_o = 1'b1;
  initial count_input_pin_b_o = 1'b1;
  // Each request gives four low cycles, then at least three high, so no edge is missed.
  always @(posedge clk_sys_i) begin
    low_a_r <= pulse_a_i ? 3'h6 : (low_a_r != 3'h0 ? low_a_r - 3'h1 : 3'h0);
    low_b_r <= pulse_b_i ? 3'h6 : (low_b_r != 3'h0 ? low_b_r - 3'h1 : 3'h0);
    count_input_pin_a_o <= !(pulse_a_i || low_a_r > 3'h3);
    count_input_pin_b_o <= !(pulse_b_i || low_b_r > 3'h3);
  end
endmodule // dtc_pin_model

/* verification/tb.sv */
// Self-checking testbench for the dual timer/counter.
`timescale 1ns/1ns
module tb;
  // ****************************************************************
  // Signals, clock and instances
  // ****************************************************************
  reg clk_sys_i = 1'b0;
  reg rst_b_i = 1'b0;
  reg [7:0] reg_addr_i = 8'h00;
  reg [7:0] reg_wdata_i = 8'h00;
  reg reg_wr_i = 1'b0;
  reg reg_rd_i = 1'b0;
  reg gate_pin_a_i = 1'b0;
  reg gate_pin_b_i = 1'b0;
  reg [1:0] ack_r = 2'h0;
  reg [1:0] pulse_r = 2'h0;
  wire [7:0] reg_rdata_o;
  wire count_input_pin_a_i;
  wire count_input_pin_b_i;
  wire overflow_flag_a_o;
  wire overflow_flag_b_o;
  wire [7:0] flags = {6'h00, overflow_flag_b_o, overflow_flag_a_o};
  integer err_total = 0;
  integer n_tests = 0;
  reg [7:0] v;
  initial forever #5 clk_sys_i = ~clk_sys_i;
  dtc_timer_pair uut (.clk_sys_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .gate_pin_a_i, .gate_pin_b_i, .count_input_pin_a_i, .count_input_pin_b_i,
    .isr_ack_a_i(ack_r[0]), .isr_ack_b_i(ack_r[1]), .overflow_flag_a_o, .overflow_flag_b_o);
  dtc_pin_model u_pins (.clk_sys_i, .pulse_a_i(pulse_r[0]), .pulse_b_i(pulse_r[1]),
    .count_input_pin_a_o(count_input_pin_a_i), .count_input_pin_b_o(count_input_pin_b_i));
  // Shared helpers: compare, bus cycles, service entry, pin pulses and flag wait.
  task chk(input [7:0] seen, input [7:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clk_sys_i); reg_wr_i <= 1'b1; reg_addr_i <= a; reg_wdata_i <= d;
    @(posedge clk_sys_i); reg_wr_i <= 1'b0;
  endtask
  task rd(input [7:0] a, output [7:0] d);
    @(posedge clk_sys_i); reg_rd_i <= 1'b1; reg_addr_i <= a;
    @(posedge clk_sys_i); reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task rdc(input [7:0] a, input [7:0] exp);
    rd(a, v);
    chk(v, exp);
  endtask
  task ack(input [1:0] sel);
    @(posedge clk_sys_i); ack_r <= sel;
    @(posedge clk_sys_i); ack_r <= 2'h0;
    #1;
  endtask
  task pulse(input [1:0] sel);
    @(posedge clk_sys_i); pulse_r <= sel;
    @(posedge clk_sys_i); pulse_r <= 2'h0;
    repeat (8) @(posedge clk_sys_i);
  endtask
  task wflag(input [7:0] mask, input integer lim);
    integer i;
    i = 0;
    #1;
    while ((flags & mask) == 8'h00 && i < lim) begin
      @(posedge clk_sys_i); #1 i = i + 1;
    end
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset values, an unmapped place, and mode register storage.
  task t_reset;
    for (int a = 8'h88; a <= 8'h8e; a++) rdc(a[7:0], 8'h00);
    wr(8'h89, 8'h5a);
    rdc(8'h89, 8'h5a);
  endtask
  // Sixteen-bit timer wraps after exactly sixteen two-cycle steps.
  task t_wide;
    wr(8'h89, 8'h01); wr(8'h8c, 8'hff); wr(8'h8a, 8'hf0); wr(8'h88, 8'h10);
    repeat (28) @(posedge clk_sys_i);
    #1 chk(flags, 8'h00);
    wflag(8'h01, 8); chk(flags, 8'h01);
    ack(2'h1); chk(flags, 8'h00);
    wr(8'h88, 8'h00); rdc(8'h8c, 8'h00);
    wr(8'h8a, 8'h33); repeat (20) @(posedge clk_sys_i); rdc(8'h8a, 8'h33);
  endtask
  // Prescaler: only the low five bits step, the upper three are kept.
  task t_prescale;
    wr(8'h89, 8'h00); wr(8'h8d, 8'hff); wr(8'h8b, 8'h3e); wr(8'h88, 8'h40);
    wflag(8'h02, 12); chk(flags, 8'h02);
    wr(8'h88, 8'h80); rdc(8'h8d, 8'h00);
    rd(8'h8b, v); chk(v & 8'he0, 8'h20);
    chk(flags, 8'h02);
    ack(2'h2); chk(flags, 8'h00);
  endtask
  // Pin-driven auto-reload with gating, while unit B is held stopped.
  task t_reload;
    wr(8'h89, 8'h36); wr(8'h8c, 8'h80); wr(8'h8a, 8'hfe); wr(8'h8b, 8'h55); wr(8'h88, 8'h50);
    pulse(2'h1); pulse(2'h1); chk(flags, 8'h01);
    rdc(8'h8a, 8'h80);
    pulse(2'h1); rdc(8'h8a, 8'h81);
    wr(8'h89, 8'h3e); pulse(2'h1); rdc(8'h8a, 8'h81);
    @(posedge clk_sys_i); gate_pin_a_i <= 1'b1; pulse(2'h1); rdc(8'h8a, 8'h82);
    rdc(8'h8b, 8'h55);
    wr(8'h88, 8'h20); chk(flags, 8'h01);
    ack(2'h1); chk(flags, 8'h00);
  endtask
  // Split mode: high byte of A runs on run B and raises flag B.
  task t_split;
    wr(8'h89, 8'h33); wr(8'h8a, 8'h77); wr(8'h8c, 8'hfe); wr(8'h88, 8'h40);
    wflag(8'h02, 12); chk(flags, 8'h02);
    rdc(8'h8a, 8'h77);
    ack(2'h2); wr(8'h8a, 8'hfe); wr(8'h88, 8'h50);
    wflag(8'h01, 12); chk(flags, 8'h01);
  endtask
  // Verdict and end of run, shared by the main sequence and the watchdog.
  task end_sim;
    $display("checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Main sequence after sixteen cycles of reset.
  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    t_reset; t_wide; t_prescale; t_reload; t_split;
    end_sim;
  end
  // The whole run needs about 250 cycles; this allows some forty times that.
  initial begin
    #100000;
    err_total = err_total + 1;
    end_sim;
  end
endmodule // tb
